// ---- bench/aeic_conv_model.sv ----
`timescale 1ns/100ps
module aeic_conv_model (
   input  wire       clk,
   input  wire       go,
   input  wire [2:0] op,
   output reg        result_valid,
   output reg        result_read,
   output reg        window_match,
   output reg        event_in,
   output wire       sync_busy,
   output reg        sync_busy_by_enable
);
   reg [1:0] busy_cnt = 2'h0;
   // one pulse per bench command with op 0 to 3, launched on the edge after go
   always @(posedge clk) begin
      result_valid <= go && op == 3'h0;
      result_read <= go && op == 3'h1;
      window_match <= go && op == 3'h2;
      event_in <= go && op == 3'h3;
   end
   // short busy episode; cause held so the design can sample it late
   always @(posedge clk) begin
      if (go && op[2]) begin
         busy_cnt <= 2'h2;
         sync_busy_by_enable <= op[0];
      end else if (busy_cnt != 2'h0) begin
         busy_cnt <= busy_cnt - 2'h1;
      end
   end
   assign sync_busy = busy_cnt != 2'h0;
endmodule

// ---- bench/aeic_ctrl_assertions.sv ----
`timescale 1ns/100ps
module aeic_chk (
   input wire       clk,
   input wire       resetn,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       result_valid,
   input wire       window_match,
   input wire       event_in,
   input wire       result_event_out,
   input wire       window_event_out,
   input wire       start_conversion,
   input wire       flush_pipeline,
   input wire [7:0] analog_route,
   input wire       irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   a_res_evt_cause: assert property (result_event_out |-> $past(result_valid))
      else $error("result event without result");
   a_win_evt_cause: assert property (window_event_out |-> $past(window_match))
      else $error("window event without match");
   a_flush_cause: assert property (flush_pipeline |-> $past(event_in))
      else $error("flush without incoming event");
   a_start_cause: assert property (start_conversion |->
      $past(event_in) || $past(event_in, 2)) else $error("start without event");
   a_clr_all_irq: assert property (reg_wr && reg_addr == 8'h16 &&
      reg_wdata[3:0] == 4'hf |=> !irq) else $error("irq after clearing enables");
   a_route_onehot: assert property ($onehot0(analog_route))
      else $error("route not one-hot");
   a_reset_quiet: assert property ($rose(resetn) |-> !irq &&
      analog_route == 8'h00 && !start_conversion) else $error("busy after reset");
endmodule

bind aeic_ctrl aeic_chk chk_u (.clk(clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_valid(result_valid),
   .window_match(window_match), .event_in(event_in),
   .result_event_out(result_event_out), .window_event_out(window_event_out),
   .start_conversion(start_conversion), .flush_pipeline(flush_pipeline),
   .analog_route(analog_route), .irq(irq));

// ---- bench/test_adc_event_interrupt_control.sv ----
`timescale 1ns/100ps
`include "aeic_map.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_adc_event_interrupt_control;
   reg clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, go = 0;
   reg [7:0] reg_addr = 0, reg_wdata = 0;
   reg [2:0] op = 0;
   reg [3:0] seen;
   wire [7:0] reg_rdata, analog_route;
   wire rv, rr, wm, ei, sb, sbe, reo, weo, stc, flp, irq;
   int errors = 0, checks = 0, cyc = 0;
   // select code to route, then event control, command, seen outputs
   localparam [12:0] rt_rows [0:9] = '{{5'h11, 8'h01}, {5'h12, 8'h02},
      {5'h13, 8'h04}, {5'h19, 8'h08}, {5'h1a, 8'h10}, {5'h1b, 8'h20},
      {5'h1c, 8'h40}, {5'h14, 8'h00}, {5'h1d, 8'h00}, {5'h05, 8'h80}};
   localparam [14:0] ev_rows [0:9] = '{{8'h00, 3'h0, 4'h0},
      {8'h00, 3'h2, 4'h0}, {8'h00, 3'h3, 4'h0}, {8'h33, 3'h0, 4'h8},
      {8'h33, 3'h2, 4'h4}, {8'h33, 3'h3, 4'h3}, {8'h01, 3'h3, 4'h2},
      {8'h02, 3'h3, 4'h3}, {8'h10, 3'h2, 4'h0}, {8'h20, 3'h0, 4'h0}};
   aeic_ctrl dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .result_valid(rv), .result_read(rr),
      .window_match(wm), .sync_busy(sb), .sync_busy_by_enable(sbe),
      .event_in(ei), .result_event_out(reo), .window_event_out(weo),
      .start_conversion(stc), .flush_pipeline(flp),
      .analog_route(analog_route), .irq(irq));
   aeic_conv_model conv_u (.clk(clk), .go(go), .op(op), .result_valid(rv),
      .result_read(rr), .window_match(wm), .event_in(ei), .sync_busy(sb),
      .sync_busy_by_enable(sbe));
   always #5 clk = ~clk;
   // hang guard, run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         end_of_test;
      end
   end
   task end_of_test;
      begin
         $display("errors %0d checks %0d", errors, checks);
         if (errors == 0 && checks > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1;
         `CHK("rdata", e, reg_rdata)
      end
   endtask
   // fire one far-side command and gather every event output it causes
   task ev(input [2:0] o);
      begin
         @(posedge clk);
         go <= 1'b1;
         op <= o;
         @(posedge clk);
         go <= 1'b0;
         seen = 4'h0;
         repeat (4) begin
            @(posedge clk);
            #1;
            seen = seen | {reo, weo, stc, flp};
         end
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rd(`AEIC_OFF_EVCTL, 8'h00);
      rd(`AEIC_OFF_IEN_CLR, 8'h00);
      rd(`AEIC_OFF_IEN_SET, 8'h00);
      for (int i = 0; i < 10; i++) begin
         wr(`AEIC_OFF_INSEL, {3'h0, rt_rows[i][12:8]});
         repeat (3) @(posedge clk);
         #1;
         `CHK("route", rt_rows[i][7:0], analog_route)
      end
      for (int i = 0; i < 10; i++) begin
         wr(`AEIC_OFF_EVCTL, ev_rows[i][14:7]);
         ev(ev_rows[i][6:4]);
         `CHK("events", ev_rows[i][3:0], seen)
      end
      wr(`AEIC_OFF_EVCTL, 8'hff);
      rd(`AEIC_OFF_EVCTL, 8'h33);
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00);
      wr(`AEIC_OFF_IFLAG, 8'h0f);
      ev(3'h1);
      wr(`AEIC_OFF_IEN_SET, 8'h05);
      rd(`AEIC_OFF_IEN_CLR, 8'h05);
      wr(`AEIC_OFF_IEN_CLR, 8'h04);
      wr(`AEIC_OFF_IEN_CLR, 8'h00);
      rd(`AEIC_OFF_IEN_SET, 8'h01);
      ev(3'h0);
      `CHK("irq", 1'b1, irq)
      wr(`AEIC_OFF_IFLAG, 8'h01);
      `CHK("irq", 1'b0, irq)
      ev(3'h0);
      ev(3'h1);
      `CHK("irq", 1'b0, irq)
      wr(`AEIC_OFF_IEN_CLR, 8'h0f);
      wr(`AEIC_OFF_IEN_SET, 8'h02);
      ev(3'h0);
      ev(3'h0);
      ev(3'h1);
      `CHK("irq", 1'b1, irq)
      wr(`AEIC_OFF_IFLAG, 8'h02);
      `CHK("irq", 1'b0, irq)
      wr(`AEIC_OFF_IEN_SET, 8'h04);
      ev(3'h2);
      `CHK("irq", 1'b1, irq)
      wr(`AEIC_OFF_IEN_CLR, 8'h0f);
      `CHK("irq", 1'b0, irq)
      wr(`AEIC_OFF_IEN_SET, 8'h04);
      `CHK("irq", 1'b1, irq)
      ev(3'h1);
      `CHK("irq", 1'b0, irq)
      wr(`AEIC_OFF_IEN_SET, 8'h08);
      ev(3'h5);
      `CHK("irq", 1'b0, irq)
      ev(3'h4);
      `CHK("irq", 1'b1, irq)
      rd(`AEIC_OFF_IFLAG, 8'h08);
      wr(`AEIC_OFF_IFLAG, 8'h08);
      `CHK("irq", 1'b0, irq)
      end_of_test;
   end
endmodule

// ---- verilog/aeic_ctrl.v ----
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "aeic_map.vh"

// Functional notes
// R01 - Select 0x11-0x13 picks pins 17-19, 0x19-0x1c internal sources.
// R02 - Event control at 0x14 holds bits 5, 4, 1 and 0, all reset to zero.
// R03 - A set window event enable emits one event per window match.
// R04 - A set result event enable emits one event per new result.
// R05 - A set flush enable makes an incoming event flush, then restart.
// R06 - A set start enable makes an incoming event start a conversion.
// R07 - Enable views at 0x16 and 0x17 hold sync, window, overrun, result.
// R08 - A one written to the clear view drops that enable and its request.
// R09 - A one written to the set view raises that enable, zeros do nothing.
// R10 - Both views read the shared enables, and irq is any enabled flag.
// R11 - The result flag sets on a new result, clears on write one or read.
// R12 - The overrun flag sets on an unread overwrite, clears on write one.
// R13 - The window flag sets a cycle after a match, clears on one or read.
// R14 - The sync flag sets when busy falls unless enable or reset caused it.
module aeic_ctrl (
   input  wire                      clk,
   input  wire                      resetn,
   input  wire [`AEIC_ADDR_W-1:0]   reg_addr,
   input  wire [7:0]                reg_wdata,
   input  wire                      reg_wr,
   input  wire                      reg_rd,
   output reg  [7:0]                reg_rdata,
   input  wire                      result_valid,
   input  wire                      result_read,
   input  wire                      window_match,
   input  wire                      sync_busy,
   input  wire                      sync_busy_by_enable,
   input  wire                      event_in,
   output reg                       result_event_out,
   output reg                       window_event_out,
   output reg                       start_conversion,
   output reg                       flush_pipeline,
   output reg  [`AEIC_RT_W-1:0]     analog_route,
   output wire                      irq
);

   // software-visible state
   reg [7:0]                  event_routing_control;
   reg [`AEIC_IRQ_W-1:0]      irq_enable;
   reg [`AEIC_IRQ_W-1:0]      irq_flag_register;
   reg [`AEIC_INSEL_W-1:0]    positive_input_select;

   // hidden tracking state
   reg                        result_unread;
   reg                        window_pending;
   reg                        busy_prev;
   reg                        busy_quiet;

   // combinational sources
   reg [`AEIC_IRQ_W-1:0]      flag_set;
   reg [`AEIC_IRQ_W-1:0]      flag_clr;
   reg [`AEIC_RT_W-1:0]       next_route;
   reg [7:0]                  next_rdata;

   // next register values
   reg [7:0]                  next_event_ctl;
   reg [`AEIC_INSEL_W-1:0]    next_select;
   reg [`AEIC_IRQ_W-1:0]      next_irq_enable;
   reg                        next_unread;
   reg                        next_quiet;

   // next event pulses
   reg                        next_result_event;
   reg                        next_window_event;
   reg                        next_flush;
   reg                        next_start;

   // qualified strobes and edges
   wire                       wr_ev;
   wire                       wr_clr;
   wire                       wr_set;
   wire                       wr_flag;
   wire                       wr_sel;
   wire                       busy_rise;
   wire                       busy_fall;
   wire                       event_flush;
   wire                       event_start;

   // route class and request bits
   wire                       select_low;
   wire [`AEIC_IRQ_W-1:0]     irq_pending;

   // read views; unused upper bits read zero
   wire [7:0]                 view_enable;
   wire [7:0]                 view_flag;
   wire [7:0]                 view_select;

   // flush sequencer states, one-hot
   localparam [1:0] SEQ_IDLE    = 2'h1;
   localparam [1:0] SEQ_RESTART = 2'h2;

   // flush sequencer state
   reg [1:0]                  seq_state;
   reg [1:0]                  next_seq_state;

   // write decode; one strobe per cycle, so at most one hit
   assign wr_ev   = reg_wr && (reg_addr == `AEIC_OFF_EVCTL);
   assign wr_clr  = reg_wr && (reg_addr == `AEIC_OFF_IEN_CLR);
   assign wr_set  = reg_wr && (reg_addr == `AEIC_OFF_IEN_SET);
   assign wr_flag = reg_wr && (reg_addr == `AEIC_OFF_IFLAG);
   assign wr_sel  = reg_wr && (reg_addr == `AEIC_OFF_INSEL);

   // next control values; undocumented event bits are dropped
   always @* begin
      next_event_ctl = event_routing_control;
      next_select    = positive_input_select;
      if (wr_ev)
         next_event_ctl = reg_wdata & `AEIC_EV_MASK;               // [R02]
      if (wr_sel)
         next_select = reg_wdata[`AEIC_INSEL_W-1:0];
   end

   // control registers
   always @(posedge clk) begin
      if (!resetn) begin
         event_routing_control <= `AEIC_ZERO8;                     // [R02]
         positive_input_select <= {`AEIC_INSEL_W{1'b0}};
      end else begin
         // both reload every cycle, holding when not written
         event_routing_control <= next_event_ctl;
         positive_input_select <= next_select;
      end
   end

   // low codes belong to the pin mux outside this block
   assign select_low = (positive_input_select < `AEIC_SEL_PIN17);

   // next enables; set and clear views never share a cycle
   always @* begin
      next_irq_enable = irq_enable;
      // clear view checked first, though both never come together
      if (wr_clr)
         next_irq_enable = irq_enable & ~reg_wdata[`AEIC_IRQ_W-1:0]; // [R08]
      else if (wr_set)
         next_irq_enable = irq_enable | reg_wdata[`AEIC_IRQ_W-1:0]; // [R09]
   end

   // one enable register stands behind both views
   always @(posedge clk) begin
      if (!resetn)
         irq_enable <= `AEIC_ZERO4;                                 // [R07]
      else
         irq_enable <= next_irq_enable;
   end

   // busy edges of the synchronisation status
   assign busy_rise = sync_busy & ~busy_prev;
   assign busy_fall = busy_prev & ~sync_busy;

   // flag set sources
   always @* begin
      flag_set = `AEIC_ZERO4;
      flag_set[`AEIC_IRQ_RES]  = result_valid;                      // [R11]
      flag_set[`AEIC_IRQ_OVR]  = result_valid & result_unread;      // [R12]
      flag_set[`AEIC_IRQ_WIN]  = window_pending;                    // [R13]
      flag_set[`AEIC_IRQ_SYNC] = busy_fall & ~busy_quiet;           // [R14]
   end

   // flag clear sources; a result read clears result and window only
   always @* begin
      flag_clr = `AEIC_ZERO4;
      // write one to clear, zeros leave a flag alone
      if (wr_flag)
         flag_clr = reg_wdata[`AEIC_IRQ_W-1:0];
      flag_clr[`AEIC_IRQ_RES] = flag_clr[`AEIC_IRQ_RES] | result_read;
      flag_clr[`AEIC_IRQ_WIN] = flag_clr[`AEIC_IRQ_WIN] | result_read;
   end

   // sticky flags, a set wins over a same-cycle clear
   genvar i;
   generate
      for (i = 0; i < `AEIC_IRQ_W; i = i + 1) begin : g_flag
         wire keep_bit;
         wire next_bit;
         // a clear only takes a flag that is not set again now
         assign keep_bit = irq_flag_register[i] & ~flag_clr[i];
         assign next_bit = flag_set[i] | keep_bit;                  // [R11]
         always @(posedge clk) begin
            if (!resetn)
               irq_flag_register[i] <= 1'b0;
            else
               irq_flag_register[i] <= next_bit;                    // [R12]
         end
      end
   endgenerate

   // request level follows enable and flag with no extra delay
   assign irq_pending = irq_enable & irq_flag_register;
   assign irq         = |irq_pending;                               // [R10]

   // next unread and quiet state
   always @* begin
      next_unread = result_unread;
      next_quiet  = busy_quiet;
      // a new result outranks a same-cycle read
      if (result_valid)
         next_unread = 1'b1;                                        // [R12]
      else if (result_read)
         next_unread = 1'b0;
      // an episode begun by enable or soft reset stays silent
      if (busy_rise)
         next_quiet = sync_busy_by_enable;                          // [R14]
      else if (!sync_busy)
         next_quiet = 1'b0;
   end

   // tracking state, window match delayed by one cycle
   always @(posedge clk) begin
      if (!resetn) begin
         result_unread  <= 1'b0;
         window_pending <= 1'b0;
         busy_prev      <= 1'b0;
         busy_quiet     <= 1'b0;
      end else begin
         result_unread  <= next_unread;
         // delayed copies for match timing and edge detection
         window_pending <= window_match;                            // [R13]
         busy_prev      <= sync_busy;
         busy_quiet     <= next_quiet;
      end
   end

   // incoming event qualified by its enables
   assign event_flush = event_in &
                        event_routing_control[`AEIC_EV_FLUSH_EI];   // [R05]
   assign event_start = event_in &
                        event_routing_control[`AEIC_EV_START_EI] &
                        ~event_routing_control[`AEIC_EV_FLUSH_EI];  // [R06]

   // flush sequencer; a restart is owed one cycle after each flush
   always @* begin
      next_seq_state = SEQ_IDLE;
      case (seq_state)
         SEQ_IDLE: begin
            if (event_flush)
               next_seq_state = SEQ_RESTART;                        // [R05]
         end
         SEQ_RESTART: begin
            if (event_flush)
               next_seq_state = SEQ_RESTART;
         end
         // unreachable codes fall back to idle
         default: begin
            next_seq_state = SEQ_IDLE;
         end
      endcase
   end

   // sequencer state register
   always @(posedge clk) begin
      if (!resetn)
         seq_state <= SEQ_IDLE;
      else
         seq_state <= next_seq_state;
   end

   // next event pulses; a flush always brings a start a cycle later
   always @* begin
      next_result_event = result_valid &
                          event_routing_control[`AEIC_EV_RES_EO];  // [R04]
      next_window_event = window_match &
                          event_routing_control[`AEIC_EV_WIN_EO];  // [R03]
      next_flush        = event_flush;
      next_start        = event_start | (seq_state == SEQ_RESTART); // [R05]
   end

   // event outputs and event-in actions, one-cycle pulses
   always @(posedge clk) begin
      if (!resetn) begin
         result_event_out <= 1'b0;
         window_event_out <= 1'b0;
         start_conversion <= 1'b0;
         flush_pipeline   <= 1'b0;
      end else begin
         // each output stands for one cycle per cause
         result_event_out <= next_result_event;
         window_event_out <= next_window_event;
         start_conversion <= next_start;
         flush_pipeline   <= next_flush;
      end
   end

   // assigned high select codes decode to one-hot analog routes
   always @* begin
      case (positive_input_select)
         `AEIC_SEL_PIN17:   next_route = `AEIC_RT_PIN17;            // [R01]
         `AEIC_SEL_PIN18:   next_route = `AEIC_RT_PIN18;
         `AEIC_SEL_PIN19:   next_route = `AEIC_RT_PIN19;
         `AEIC_SEL_BANDGAP: next_route = `AEIC_RT_BANDGAP;          // [R01]
         `AEIC_SEL_QCORE:   next_route = `AEIC_RT_QCORE;
         `AEIC_SEL_QIO:     next_route = `AEIC_RT_QIO;
         `AEIC_SEL_DAC:     next_route = `AEIC_RT_DAC;
         default: begin
            // low codes go to the pin mux outside, reserved go nowhere
            if (select_low)
               next_route = `AEIC_RT_LOWPIN;
            else
               next_route = `AEIC_RT_NONE;                          // [R01]
         end
      endcase
   end

   // registered route so the analog switches never see decode glitches
   always @(posedge clk) begin
      if (!resetn)
         analog_route <= `AEIC_RT_NONE;
      else
         analog_route <= next_route;
   end

   // read views; both enable views share one image
   assign view_enable = {4'h0, irq_enable};                         // [R10]
   assign view_flag   = {4'h0, irq_flag_register};
   assign view_select = {3'h0, positive_input_select};

   // read mux; unmapped addresses read zero
   always @* begin
      next_rdata = `AEIC_ZERO8;
      case (reg_addr)
         `AEIC_OFF_EVCTL:   next_rdata = event_routing_control;
         `AEIC_OFF_IEN_CLR: next_rdata = view_enable;               // [R10]
         `AEIC_OFF_IEN_SET: next_rdata = view_enable;               // [R10]
         `AEIC_OFF_IFLAG:   next_rdata = view_flag;
         `AEIC_OFF_STATUS:  next_rdata[`AEIC_ST_BUSY] = sync_busy;
         `AEIC_OFF_INSEL:   next_rdata = view_select;
         default:           next_rdata = `AEIC_ZERO8;
      endcase
   end

   // read data valid in the cycle after the strobe only
   always @(posedge clk) begin
      if (!resetn)
         reg_rdata <= `AEIC_ZERO8;
      else if (reg_rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= `AEIC_ZERO8;
   end

endmodule

// ---- verilog/aeic_map.vh ----
`ifndef AEIC_MAP_VH
`define AEIC_MAP_VH

// register offsets, byte addressed on the plain port
`define AEIC_ADDR_W        8
`define AEIC_OFF_EVCTL     8'h14
`define AEIC_OFF_IEN_CLR   8'h16
`define AEIC_OFF_IEN_SET   8'h17
`define AEIC_OFF_IFLAG     8'h18
`define AEIC_OFF_STATUS    8'h19
`define AEIC_OFF_INSEL     8'h10

// event control fields
`define AEIC_EV_WIN_EO     5
`define AEIC_EV_RES_EO     4
`define AEIC_EV_FLUSH_EI   1
`define AEIC_EV_START_EI   0
`define AEIC_EV_MASK       8'h33

// interrupt bit positions, shared by enables and flags
`define AEIC_IRQ_SYNC      3
`define AEIC_IRQ_WIN       2
`define AEIC_IRQ_OVR       1
`define AEIC_IRQ_RES       0
`define AEIC_IRQ_W         4

// status register
`define AEIC_ST_BUSY       7

// positive input select codes
`define AEIC_INSEL_W       5
`define AEIC_SEL_PIN17     5'h11
`define AEIC_SEL_PIN18     5'h12
`define AEIC_SEL_PIN19     5'h13
`define AEIC_SEL_BANDGAP   5'h19
`define AEIC_SEL_QCORE     5'h1a
`define AEIC_SEL_QIO       5'h1b
`define AEIC_SEL_DAC       5'h1c

// analog route one-hot outputs
`define AEIC_RT_W          8
`define AEIC_RT_NONE       8'h00
`define AEIC_RT_PIN17      8'h01
`define AEIC_RT_PIN18      8'h02
`define AEIC_RT_PIN19      8'h04
`define AEIC_RT_BANDGAP    8'h08
`define AEIC_RT_QCORE      8'h10
`define AEIC_RT_QIO        8'h20
`define AEIC_RT_DAC        8'h40
`define AEIC_RT_LOWPIN     8'h80

`define AEIC_ZERO8         8'h00
`define AEIC_ZERO4         4'h0

`endif
